//--- src/iss_map.svh
// Offsets, field positions, reset values and vectors of the interrupt stack sequencer
`ifndef ISS_MAP_SVH
`define ISS_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ISS_ADDR_SERIAL_MODE 8'hf6
`define ISS_ADDR_INT_CTRL    8'hfe
`define ISS_ADDR_TMR_CTRL    8'hff

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ISS_SER_SRC_BIT      2
`define ISS_STACK_PAGE_BIT   4
`define ISS_IC_PIN1_REQ      0
`define ISS_IC_PIN1_EN       1
`define ISS_IC_TMRX_REQ      2
`define ISS_IC_TMRX_EN       3
`define ISS_IC_PIN2_REQ      4
`define ISS_IC_PIN2_EN       5
`define ISS_TC_TMR1_REQ      0
`define ISS_TC_TMR1_EN       1
`define ISS_TC_TMR2_REQ      2
`define ISS_TC_TMR2_EN       3
`define ISS_ST_IRQ_OFF       2
`define ISS_ST_BREAK         4

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define ISS_ST_RESET         8'h04
`define ISS_ST_FLAG_MASK     8'heb
`define ISS_SER_RESET        4'h0
`define ISS_SPARE_RESET      3'h0

// ----------------------------------------------------------------------------
// Vector low-byte addresses; the high byte sits one above
// ----------------------------------------------------------------------------
`define ISS_VEC_RESET        16'hfffe
`define ISS_VEC_PIN1         16'hfffc
`define ISS_VEC_TMRX         16'hfffa
`define ISS_VEC_TMR1         16'hfff8
`define ISS_VEC_TMR2         16'hfff6
`define ISS_VEC_PIN2         16'hfff4
`define ISS_SRC_RESET        3'h5

`endif

//--- src/iss_pkg.sv
// Types of the interrupt stack sequencer
package iss_pkg;

	typedef enum logic [3:0] {
		op_push_accumulator     = 4'h0,
		op_pull_accumulator     = 4'h1,
		op_push_status          = 4'h2,
		op_pull_status          = 4'h3,
		op_call                 = 4'h4,
		op_sub_return           = 4'h5,
		op_interrupt_return     = 4'h6,
		op_software_break       = 4'h7,
		op_set_interrupt_disable   = 4'h8,
		op_clear_interrupt_disable = 4'h9,
		op_index_to_stack_transfer = 4'ha,
		op_irq_entry            = 4'hb,
		op_reset_entry          = 4'hc
	} iss_op_t;

	typedef enum logic [2:0] {
		st_idle      = 3'h0,
		st_push      = 3'h1,
		st_pull_addr = 3'h2,
		st_pull_data = 3'h3,
		st_vec_addr  = 3'h4,
		st_vec_wait  = 3'h5,
		st_vec_data  = 3'h6
	} iss_state_t;

	typedef enum logic [1:0] {
		item_pch    = 2'h0,
		item_pcl    = 2'h1,
		item_status = 2'h2,
		item_acc    = 2'h3
	} iss_item_t;

endpackage

//--- src/iss_stack_ram.sv
// Two-page stack memory with registered read data
`timescale 1ns/1ps
module iss_stack_ram (
	input  wire logic       clk_sys_i,
	input  wire logic       we_i,
	input  wire logic       re_i,
	input  wire logic [8:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] mem [0:511];
	logic [7:0] rdata_reg;

	// No reset on the array: stack contents are undefined until pushed
	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		if (re_i) begin
			rdata_reg <= mem[addr_i];
		end
	end

	assign rdata_o = rdata_reg;
endmodule

//--- src/iss_top.sv
// Interrupt entry, priority selection and stack sequencing for an 8-bit core
//
// Summary of operation
// [RL1] Stack pointer eight bits, no reset
// [RL2] Stack page bit selects address high byte
// [RL3] Software keeps page zero in single-chip use
// [RL4] Entry pushes counter high, counter low, status
// [RL5] Interrupt return pulls status then counter
// [RL6] Accumulator only by push and pull commands
// [RL7] Status push and pull commands
// [RL8] Call pushes counter only; return restores it
// [RL9] Sixteen-bit program counter from two halves
// [RL10] Acceptance sets interrupt disable; set/clear commands
// [RL11] Break uses lowest-priority vector entry sequence
// [RL12] Break flag marks software-break entries
// [RL13] Fixed priorities and vector pairs
// [RL14] Five request sources accepted
// [RL15] Serial mode bit two picks fifth source
// [RL16] Software makes shared pin an input
// [RL17] Acceptance stacks, vectors, clears request
// [RL18] Reset highest priority, never masked
// [RL19] Disable flag and enables gate requests
// [RL20] Smallest priority number served first
// [RL21] Requests checked only at instruction boundaries
`timescale 1ns/1ps
`include "iss_map.svh"
module iss_top (
	input  wire logic            clk_sys_i,
	input  wire logic            arst_n_i,
	input  wire logic [7:0]      reg_addr_i,
	input  wire logic            reg_wr_i,
	input  wire logic            reg_rd_i,
	input  wire logic [7:0]      reg_wdata_i,
	output logic      [7:0]      reg_rdata_o,
	input  wire logic            boundary_i,
	input  wire logic            cmd_valid_i,
	input  iss_pkg::iss_op_t     cmd_op_i,
	input  wire logic [7:0]      cmd_data_i,
	input  wire logic [15:0]     pc_i,
	input  wire logic            flags_wr_i,
	input  wire logic [7:0]      flags_i,
	input  wire logic            pin_interrupt_one_n_i,
	input  wire logic            shared_port_pin_i,
	input  wire logic            timer_x_evt_i,
	input  wire logic            timer1_evt_i,
	input  wire logic            timer2_evt_i,
	input  wire logic            serial_done_i,
	output logic                 vec_rd_o,
	output logic      [15:0]     vec_addr_o,
	input  wire logic [7:0]      vec_data_i,
	output logic      [15:0]     program_counter_o,
	output logic                 pc_load_o,
	output logic      [7:0]      processor_status_o,
	output logic      [7:0]      acc_o,
	output logic                 acc_load_o,
	output logic      [7:0]      sp_o,
	output logic                 busy_o,
	output logic                 done_o
);
	import iss_pkg::*;

	// ------------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------------
	function automatic logic [1:0] seq_len(input iss_op_t op);
		unique case (op)
			op_call, op_sub_return:                          seq_len = 2'h2;
			op_interrupt_return, op_software_break, op_irq_entry: seq_len = 2'h3;
			default:                                         seq_len = 2'h1;
		endcase
	endfunction

	function automatic iss_item_t seq_item(input iss_op_t op, input logic [1:0] idx);
		unique case (op)
			op_push_accumulator, op_pull_accumulator: seq_item = item_acc;
			op_push_status, op_pull_status:           seq_item = item_status;
			op_interrupt_return:
				seq_item = (idx == 2'h0) ? item_status : ((idx == 2'h1) ? item_pcl : item_pch);
			op_sub_return:
				seq_item = (idx == 2'h0) ? item_pcl : item_pch;
			default:
				seq_item = (idx == 2'h0) ? item_pch : ((idx == 2'h1) ? item_pcl : item_status);
		endcase
	endfunction

	function automatic logic [15:0] vec_base(input logic [2:0] src);
		unique case (src)
			3'h0:    vec_base = `ISS_VEC_PIN1;
			3'h1:    vec_base = `ISS_VEC_TMRX;
			3'h2:    vec_base = `ISS_VEC_TMR1;
			3'h3:    vec_base = `ISS_VEC_TMR2;
			3'h4:    vec_base = `ISS_VEC_PIN2;
			default: vec_base = `ISS_VEC_RESET;
		endcase
	endfunction

	function automatic logic [2:0] first_set(input logic [4:0] vec);
		first_set = 3'h0;
		for (int i = 4; i >= 0; i--) begin
			if (vec[i]) begin
				first_set = 3'(i);
			end
		end
	endfunction

	// ------------------------------------------------------------------------
	// Pin synchronisers and request sources
	// ------------------------------------------------------------------------
	logic [1:0] pin_meta_reg;
	logic [1:0] pin_sync_reg;
	logic [1:0] pin_prev_reg;
	logic [1:0] pin_fall;
	logic [4:0] evt;
	logic [4:0] req_reg,  req_next;
	logic [4:0] en_reg,   en_next;
	logic [3:0] ser_mode_reg, ser_mode_next;
	logic       page_reg, page_next;
	logic [1:0] ic_spare_reg, ic_spare_next;
	logic [2:0] tc_spare_reg, tc_spare_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [4:0] sw_clr;
	logic [4:0] take_mask;
	logic [4:0] irq_pend;
	logic       irq_take;
	logic       wr_ic;
	logic       wr_tc;

	// Active-low pins: a falling edge raises the request
	assign pin_fall = pin_prev_reg & ~pin_sync_reg;
	assign evt = {pin_fall[1],
		ser_mode_reg[`ISS_SER_SRC_BIT] ? serial_done_i : timer2_evt_i, // RL15
		timer1_evt_i, timer_x_evt_i, pin_fall[0]};                      // RL14

	assign wr_ic = reg_wr_i && (reg_addr_i == `ISS_ADDR_INT_CTRL);
	assign wr_tc = reg_wr_i && (reg_addr_i == `ISS_ADDR_TMR_CTRL);

	always_comb begin
		sw_clr        = 5'h0;
		en_next       = en_reg;
		ser_mode_next = ser_mode_reg;
		page_next     = page_reg;
		ic_spare_next = ic_spare_reg;
		tc_spare_next = tc_spare_reg;
		rdata_next    = rdata_reg;
		if (wr_ic) begin
			sw_clr[0] = ~reg_wdata_i[`ISS_IC_PIN1_REQ];
			sw_clr[1] = ~reg_wdata_i[`ISS_IC_TMRX_REQ];
			sw_clr[4] = ~reg_wdata_i[`ISS_IC_PIN2_REQ];
			en_next[0] = reg_wdata_i[`ISS_IC_PIN1_EN];
			en_next[1] = reg_wdata_i[`ISS_IC_TMRX_EN];
			en_next[4] = reg_wdata_i[`ISS_IC_PIN2_EN];
			ic_spare_next = reg_wdata_i[7:6];
		end
		if (wr_tc) begin
			sw_clr[2] = ~reg_wdata_i[`ISS_TC_TMR1_REQ];
			sw_clr[3] = ~reg_wdata_i[`ISS_TC_TMR2_REQ];
			en_next[2] = reg_wdata_i[`ISS_TC_TMR1_EN];
			en_next[3] = reg_wdata_i[`ISS_TC_TMR2_EN];
			page_next  = reg_wdata_i[`ISS_STACK_PAGE_BIT];
			tc_spare_next = reg_wdata_i[7:5];
		end
		if (reg_wr_i && (reg_addr_i == `ISS_ADDR_SERIAL_MODE)) begin
			ser_mode_next = reg_wdata_i[3:0];
		end
		// A new event beats both the software clear and the acceptance clear
		req_next = (req_reg & ~sw_clr & ~take_mask) | evt; // RL17
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`ISS_ADDR_SERIAL_MODE: rdata_next = {4'h0, ser_mode_reg};
				`ISS_ADDR_INT_CTRL:
					rdata_next = {ic_spare_reg, en_reg[4], req_reg[4],
						en_reg[1], req_reg[1], en_reg[0], req_reg[0]};
				`ISS_ADDR_TMR_CTRL:
					rdata_next = {tc_spare_reg, page_reg,
						en_reg[3], req_reg[3], en_reg[2], req_reg[2]};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_meta_reg <= 2'h3;
			pin_sync_reg <= 2'h3;
			pin_prev_reg <= 2'h3;
			req_reg      <= 5'h00;
			en_reg       <= 5'h00;
			ser_mode_reg <= `ISS_SER_RESET;
			page_reg     <= 1'b0;
			ic_spare_reg <= 2'h0;
			tc_spare_reg <= `ISS_SPARE_RESET;
			rdata_reg    <= 8'h00;
		end else begin
			pin_meta_reg <= {shared_port_pin_i, pin_interrupt_one_n_i};
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
			req_reg      <= req_next;
			en_reg       <= en_next;
			ser_mode_reg <= ser_mode_next;
			page_reg     <= page_next;
			ic_spare_reg <= ic_spare_next;
			tc_spare_reg <= tc_spare_next;
			rdata_reg    <= rdata_next;
		end
	end

	// ------------------------------------------------------------------------
	// Acceptance and stack sequencer
	// ------------------------------------------------------------------------
	iss_state_t  state_reg, state_next;
	iss_op_t     op_reg,    op_next;
	logic [1:0]  idx_reg,   idx_next;
	logic [2:0]  src_reg,   src_next;
	logic        by_break_reg, by_break_next;
	logic [15:0] pc_reg,    pc_next;
	logic [7:0]  status_reg, status_next;
	logic [7:0]  acc_reg,   acc_next;
	logic [7:0]  sp_reg,    sp_next;
	logic        acc_load_reg, acc_load_next;
	logic        pc_load_reg,  pc_load_next;
	logic        vec_rd_reg,   vec_rd_next;
	logic [15:0] vec_addr_reg, vec_addr_next;
	logic        busy_reg,  busy_next;
	logic        done_reg,  done_next;
	logic        ram_we;
	logic        ram_re;
	logic [8:0]  ram_addr;
	logic [7:0]  ram_wdata;
	logic [7:0]  ram_rdata;
	logic        is_entry;
	logic        last_item;
	iss_item_t   cur_item;
	logic [7:0]  entry_status;

	assign irq_pend  = req_reg & en_reg;                                        // RL19
	assign irq_take  = (state_reg == st_idle) && boundary_i                     // RL21
		&& !status_reg[`ISS_ST_IRQ_OFF] && (irq_pend != 5'h0);                  // RL19
	assign take_mask = irq_take ? (5'h01 << first_set(irq_pend)) : 5'h00;       // RL20
	assign is_entry  = (op_reg == op_irq_entry) || (op_reg == op_software_break);
	assign cur_item  = seq_item(op_reg, idx_reg);
	assign last_item = (idx_reg == (seq_len(op_reg) - 2'h1));
	assign entry_status = by_break_reg ? (status_reg | (8'h01 << `ISS_ST_BREAK)) // RL12
		: (status_reg & ~(8'h01 << `ISS_ST_BREAK));

	always_comb begin
		state_next = state_reg;
		op_next    = op_reg;
		idx_next   = idx_reg;
		src_next   = src_reg;
		by_break_next = by_break_reg;
		pc_next    = pc_reg;
		status_next = status_reg;
		acc_next   = acc_reg;
		sp_next    = sp_reg;
		acc_load_next = 1'b0;
		pc_load_next  = 1'b0;
		vec_rd_next   = 1'b0;
		vec_addr_next = vec_addr_reg;
		done_next  = 1'b0;
		ram_we     = 1'b0;
		ram_re     = 1'b0;
		ram_addr   = {page_reg, sp_reg};                                        // RL2
		ram_wdata  = acc_reg;
		if (flags_wr_i) begin
			status_next = (status_reg & ~`ISS_ST_FLAG_MASK) | (flags_i & `ISS_ST_FLAG_MASK);
		end
		unique case (state_reg)
			st_idle: begin
				idx_next = 2'h0;
				if (irq_take) begin
					op_next    = op_irq_entry;
					src_next   = first_set(irq_pend);                           // RL20
					by_break_next = 1'b0;
					pc_next    = pc_i;
					state_next = st_push;                                       // RL17
				end else if (cmd_valid_i) begin
					op_next  = cmd_op_i;
					pc_next  = pc_i;
					acc_next = cmd_data_i;
					by_break_next = (cmd_op_i == op_software_break);
					src_next = 3'h4;                                            // RL11
					unique case (cmd_op_i)
						op_push_accumulator, op_push_status, op_call, op_software_break:
							state_next = st_push;                               // RL6 RL7 RL8 RL11
						op_pull_accumulator, op_pull_status, op_sub_return,
						op_interrupt_return:
							state_next = st_pull_addr;                          // RL5 RL6 RL7 RL8
						op_set_interrupt_disable: begin
							status_next[`ISS_ST_IRQ_OFF] = 1'b1;                // RL10
							done_next = 1'b1;
						end
						op_clear_interrupt_disable: begin
							status_next[`ISS_ST_IRQ_OFF] = 1'b0;                // RL10
							done_next = 1'b1;
						end
						op_index_to_stack_transfer: begin
							sp_next   = cmd_data_i;                             // RL1
							done_next = 1'b1;
						end
						default: done_next = 1'b1;
					endcase
				end
			end
			st_push: begin
				ram_we = 1'b1;
				unique case (cur_item)                                          // RL4
					item_pch:    ram_wdata = pc_reg[15:8];
					item_pcl:    ram_wdata = pc_reg[7:0];
					item_status: ram_wdata = is_entry ? entry_status : status_reg;
					item_acc:    ram_wdata = acc_reg;
				endcase
				sp_next = sp_reg - 8'h01;                                       // RL4
				idx_next = idx_reg + 2'h1;
				if (last_item) begin
					idx_next = 2'h0;
					if (is_entry) begin
						status_next[`ISS_ST_IRQ_OFF] = 1'b1;                    // RL10
						status_next[`ISS_ST_BREAK]   = by_break_reg;            // RL12
						state_next = st_vec_addr;
					end else begin
						done_next  = 1'b1;
						state_next = st_idle;
					end
				end
			end
			st_pull_addr: begin
				ram_re     = 1'b1;
				ram_addr   = {page_reg, sp_reg + 8'h01};
				sp_next    = sp_reg + 8'h01;
				state_next = st_pull_data;
			end
			st_pull_data: begin
				unique case (cur_item)                                          // RL5
					item_pch:    pc_next[15:8] = ram_rdata;
					item_pcl:    pc_next[7:0]  = ram_rdata;
					item_status: status_next   = ram_rdata;
					item_acc:    acc_next      = ram_rdata;
				endcase
				idx_next   = idx_reg + 2'h1;
				state_next = st_pull_addr;
				if (last_item) begin
					idx_next      = 2'h0;
					done_next     = 1'b1;
					state_next    = st_idle;
					pc_load_next  = (op_reg == op_sub_return) || (op_reg == op_interrupt_return);
					acc_load_next = (op_reg == op_pull_accumulator);
				end
			end
			st_vec_addr: begin
				vec_rd_next   = 1'b1;
				vec_addr_next = vec_base(src_reg) | {15'h0000, ~idx_reg[0]};    // RL13
				state_next    = st_vec_wait;
			end
			st_vec_wait: begin
				state_next = st_vec_data;
			end
			st_vec_data: begin
				if (idx_reg == 2'h0) begin
					pc_next[15:8] = vec_data_i;                                 // RL9
					idx_next      = 2'h1;
					state_next    = st_vec_addr;
				end else begin
					pc_next[7:0]  = vec_data_i;                                 // RL9
					idx_next      = 2'h0;
					pc_load_next  = 1'b1;
					done_next     = 1'b1;
					state_next    = st_idle;
				end
			end
			default: state_next = st_idle;
		endcase
		busy_next = (state_next != st_idle);
	end

	// Reset itself runs as the first, unmaskable entry: vector only, no stacking
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg    <= st_vec_addr;                                        // RL18
			op_reg       <= op_reset_entry;
			idx_reg      <= 2'h0;
			src_reg      <= `ISS_SRC_RESET;                                     // RL18
			by_break_reg <= 1'b0;
			pc_reg       <= 16'h0000;
			status_reg   <= `ISS_ST_RESET;
			acc_reg      <= 8'h00;
			acc_load_reg <= 1'b0;
			pc_load_reg  <= 1'b0;
			vec_rd_reg   <= 1'b0;
			vec_addr_reg <= 16'h0000;
			busy_reg     <= 1'b1;
			done_reg     <= 1'b0;
		end else begin
			state_reg    <= state_next;
			op_reg       <= op_next;
			idx_reg      <= idx_next;
			src_reg      <= src_next;
			by_break_reg <= by_break_next;
			pc_reg       <= pc_next;
			status_reg   <= status_next;
			acc_reg      <= acc_next;
			acc_load_reg <= acc_load_next;
			pc_load_reg  <= pc_load_next;
			vec_rd_reg   <= vec_rd_next;
			vec_addr_reg <= vec_addr_next;
			busy_reg     <= busy_next;
			done_reg     <= done_next;
		end
	end

	// Deliberately without reset: software must load it before any stacking
	always_ff @(posedge clk_sys_i) begin
		sp_reg <= sp_next;                                                      // RL1
	end

	iss_stack_ram u_stack_ram (
		.clk_sys_i (clk_sys_i),
		.we_i      (ram_we),
		.re_i      (ram_re),
		.addr_i    (ram_addr),
		.wdata_i   (ram_wdata),
		.rdata_o   (ram_rdata)
	);

	assign reg_rdata_o        = rdata_reg;
	assign vec_rd_o           = vec_rd_reg;
	assign vec_addr_o         = vec_addr_reg;
	assign program_counter_o  = pc_reg;
	assign pc_load_o          = pc_load_reg;
	assign processor_status_o = status_reg;
	assign acc_o              = acc_reg;
	assign acc_load_o         = acc_load_reg;
	assign sp_o               = sp_reg;
	assign busy_o             = busy_reg;
	assign done_o             = done_reg;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb_sys @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	a_push_sp_dec: assert property ((state_reg == st_push) |=> (sp_reg == $past(sp_reg) - 8'h01)) // RL4
		else $error("stack pointer not decremented after push");
	a_stack_page: assert property ((ram_we || ram_re) |-> (ram_addr[8] == page_reg)) // RL2
		else $error("stack access outside selected page");
	a_entry_order: assert property ((state_reg == st_push && op_reg == op_irq_entry && idx_reg == 2'h0) // RL4
		|-> (ram_wdata == pc_reg[15:8]) ##1 (ram_wdata == pc_reg[7:0])
		##1 (ram_wdata[`ISS_ST_BREAK] == 1'b0))
		else $error("entry push order wrong");
	a_entry_disable: assert property ((state_reg == st_push && is_entry && last_item) // RL10
		|=> status_reg[`ISS_ST_IRQ_OFF] ##1 vec_rd_o)
		else $error("entry did not set disable flag and fetch vector");
	a_break_flag: assert property ((state_reg == st_vec_addr && op_reg != op_reset_entry) // RL12
		|-> (status_reg[`ISS_ST_BREAK] == (op_reg == op_software_break)))
		else $error("break flag does not match cause");
	a_masked: assert property ((state_reg == st_idle && status_reg[`ISS_ST_IRQ_OFF]) // RL19
		|=> !(state_reg == st_push && op_reg == op_irq_entry))
		else $error("interrupt taken while disabled");
	a_boundary_only: assert property ((state_reg == st_idle && !boundary_i) // RL21
		|=> !(state_reg == st_push && op_reg == op_irq_entry))
		else $error("interrupt taken off a boundary");
	a_priority: assert property (irq_take |-> (take_mask == (irq_pend & (~irq_pend + 5'h01)))) // RL20
		else $error("not the highest-priority request");
	a_req_clear: assert property ((irq_take && ((evt & take_mask) == 5'h00)) // RL17
		|=> ((req_reg & $past(take_mask)) == 5'h00))
		else $error("accepted request not cleared");
	a_vec_range: assert property ((state_reg == st_vec_data && idx_reg == 2'h1) // RL13
		|=> pc_load_o && (program_counter_o == {$past(pc_reg[15:8]), $past(vec_data_i)}))
		else $error("vector not loaded high byte first");

	c_irq_entry: cover property ((state_reg == st_push && op_reg == op_irq_entry) ##[1:20] done_o);
	c_break:     cover property ((state_reg == st_push && op_reg == op_software_break) ##[1:20] done_o);
	c_int_ret:   cover property ((state_reg == st_pull_data && op_reg == op_interrupt_return) ##[1:10] pc_load_o);
	c_two_pend:  cover property (irq_take && ($countones(irq_pend) > 1));
endmodule

//--- dv/iss_vec_mem.sv
// Program memory model that answers vector reads one cycle late
`timescale 1ns/1ps
module iss_vec_mem (
	input  wire logic        clk_sys_i,
	input  wire logic        vec_rd_i,
	input  wire logic [15:0] vec_addr_i,
	output logic      [7:0]  vec_data_o
);
	// Stale data flips each cycle so a late sample cannot match
	always_ff @(posedge clk_sys_i) begin
		if (vec_rd_i)
			vec_data_o <= vec_addr_i[7:0] ^ 8'h3c;
		else
			vec_data_o <= ~vec_data_o;
	end
endmodule

//--- dv/iss_top_tb.sv
// Self-checking bench for the interrupt stack sequencer
`timescale 1ns/1ps
module iss_top_tb;
	import iss_pkg::*;
	logic clk_sys_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, bnd = 0, cv = 0, fw = 0;
	logic tx = 0, t1 = 0, p1_n = 1, p2_n = 1, t2 = 0, sd = 0, vrd, pcl, accl, busy, done;
	logic [7:0] ra = 0, wd = 0, cd = 0, fl = 0, rdata, vdata, st, acc, sp;
	logic [15:0] pc_i = 0, vaddr, pc;
	iss_op_t op = op_call;
	int n_fail = 0, tests_run = 0;
	always #50 clk_sys_i = ~clk_sys_i;
	iss_top uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(ra), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_wdata_i(wd), .reg_rdata_o(rdata), .boundary_i(bnd),
		.cmd_valid_i(cv), .cmd_op_i(op), .cmd_data_i(cd), .pc_i(pc_i), .flags_wr_i(fw),
		.flags_i(fl), .pin_interrupt_one_n_i(p1_n), .shared_port_pin_i(p2_n),
		.timer_x_evt_i(tx), .timer1_evt_i(t1), .timer2_evt_i(t2), .serial_done_i(sd),
		.vec_rd_o(vrd), .vec_addr_o(vaddr), .vec_data_i(vdata), .program_counter_o(pc),
		.pc_load_o(pcl), .processor_status_o(st), .acc_o(acc), .acc_load_o(accl), .sp_o(sp),
		.busy_o(busy), .done_o(done));
	iss_vec_mem mem (.clk_sys_i(clk_sys_i), .vec_rd_i(vrd), .vec_addr_i(vaddr), .vec_data_o(vdata));
	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wdone;
		int k;
		for (k = 0; k < 40; k++) begin
			@(negedge clk_sys_i);
			cv = 0;
			if (done === 1'b1)
				break;
		end
		chk("done", done, 1);
	endtask
	task automatic cmd(iss_op_t o, logic [7:0] d);
		op = o;
		cd = d;
		cv = 1;
		wdone;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		ra = a;
		wd = d;
		reg_wr_i = 1;
		@(negedge clk_sys_i);
		reg_wr_i = 0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		ra = a;
		reg_rd_i = 1;
		@(negedge clk_sys_i);
		reg_rd_i = 0;
		@(negedge clk_sys_i);
		chk("rdata", rdata, e);
	endtask
	task automatic flg(logic [7:0] v);
		fl = v;
		fw = 1;
		@(negedge clk_sys_i);
		fw = 0;
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		#200us;
		n_fail++;
		results;
	end
	initial begin
		repeat (12) @(negedge clk_sys_i);
		arst_n_i = 1;
		wdone;
		chk("pc", pc, 16'hc3c2);
		chk("status", st, 8'h04);
		wr(8'hf6, 8'hff);
		rd(8'hf6, 8'h0f);
		rd(8'h10, 8'h00);
		$display("reset and registers done");
		wr(8'hff, 8'h00);
		cmd(op_index_to_stack_transfer, 8'h7f);
		chk("sp", sp, 8'h7f);
		flg(8'hff);
		cmd(op_push_accumulator, 8'ha5);
		cmd(op_push_status, 0);
		chk("sp", sp, 8'h7d);
		flg(8'h00);
		cmd(op_pull_status, 0);
		chk("status", st, 8'hef);
		cmd(op_pull_accumulator, 0);
		chk("acc", {sp, acc}, 16'h7fa5);
		chk("acc_load", accl, 1);
		pc_i = 16'h1234;
		cmd(op_call, 0);
		chk("sp", sp, 8'h7d);
		pc_i = 0;
		cmd(op_sub_return, 0);
		chk("pc", {pc}, 16'h1234);
		chk("pc_load", pcl, 1);
		$display("stack commands done");
		wr(8'hfe, 8'h08);
		wr(8'hff, 8'h02);
		tx = 1;
		t1 = 1;
		@(negedge clk_sys_i);
		tx = 0;
		t1 = 0;
		cmd(op_clear_interrupt_disable, 0);
		pc_i = 16'h4321;
		bnd = 1;
		wdone;
		chk("pc", pc, 16'hc7c6);
		chk("status", st & 8'h14, 8'h04);
		chk("sp", sp, 8'h7c);
		chk("vec_addr", vaddr, 16'hfffa);
		rd(8'hfe, 8'h08);
		rd(8'hff, 8'h03);
		cmd(op_interrupt_return, 0);
		chk("pc", pc, 16'h4321);
		chk("status", st, 8'heb);
		wdone;
		chk("pc", pc, 16'hc5c4);
		$display("interrupt entry done");
		bnd = 0;
		cmd(op_software_break, 0);
		chk("pc", pc, 16'hc9c8);
		chk("break_flag", st[4], 1);
		$display("break done");
		wr(8'hfe, 8'h22);
		wr(8'hff, 8'h08);
		t2 = 1;
		@(negedge clk_sys_i);
		t2 = 0;
		rd(8'hff, 8'h08);
		sd = 1;
		p1_n = 0;
		p2_n = 0;
		@(negedge clk_sys_i);
		sd = 0;
		repeat (2) @(negedge clk_sys_i);
		rd(8'hfe, 8'h33);
		rd(8'hff, 8'h0c);
		cmd(op_clear_interrupt_disable, 0);
		bnd = 1;
		wdone;
		chk("pc", pc, 16'hc1c0);
		chk("break_flag", st[4], 0);
		rd(8'hfe, 8'h32);
		$display("pin interrupts done");
		arst_n_i = 0;
		@(negedge clk_sys_i);
		chk("busy", busy, 1);
		arst_n_i = 1;
		wdone;
		chk("pc", pc, 16'hc3c2);
		chk("busy", busy, 0);
		$display("second reset done");
		results;
	end
endmodule
